// ===== rtl/exec_consts.svh
// constant names for the second-part instruction executor
// assumes a 16-bit instruction word and a 13-bit program counter
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

`define PC_RST        13'h0000
`define BYTE_RST      8'h00
`define PC_STEP       13'h0001

`define GRP_FILE      2'b00
`define GRP_LIT       2'b01
`define CALL_FIELD    3'b100

`define SUB_MOVE      4'b1000
`define SUB_STORE     4'b0000
`define SUB_ROT_L     4'b1101
`define SUB_ROT_R     4'b1100
`define SUB_MINUS     4'b0010
`define SUB_SWAP      4'b1110
`define SUB_XOR       4'b0110

`define LIT_MOVE      8'h19
`define LIT_POP       8'h18
`define LIT_MINUS     8'h1F
`define LIT_XOR       8'h1D
`define WORD_SLEEP    16'h1E03
`define WORD_IDLE     16'h0000
`define WORD_RET      16'h0040
`define WORD_INTERRUPT_EXIT_OP     16'h0060
`define WORD_ROM_HI   16'h0058
`define WORD_ROM_LO   16'h0050

`define REG_STATUS    8'h00
`define REG_ACC       8'h04
`define REG_TABLE     8'h08
`define REG_PTR_LO    8'h0C
`define REG_PTR_HI    8'h10

`define ST_C          0
`define ST_DC         1
`define ST_Z          2
`define ST_PD         3
`define ST_TO         4
`define ST_GIE        5

`endif

// ===== rtl/exec_pkg.sv
// types shared by the instruction executor and its bench
// assumes nothing beyond a SystemVerilog package scope
package exec_pkg;

  typedef enum logic [1:0] {
    ST_EXEC   = 2'b00,
    ST_SECOND = 2'b01,
    ST_SLEEP  = 2'b10
  } state_e;

  typedef enum logic [3:0] {
    OP_IDLE       = 4'b0000,
    OP_FILE_ACC   = 4'b0001,
    OP_LIT_ACC    = 4'b0010,
    OP_ACC_FILE   = 4'b0011,
    OP_POP_PC     = 4'b0100,
    OP_IRQ_EXIT   = 4'b0101,
    OP_LIT_POP    = 4'b0110,
    OP_ROT_L      = 4'b0111,
    OP_ROT_R      = 4'b1000,
    OP_SLEEP      = 4'b1001,
    OP_LIT_MINUS  = 4'b1010,
    OP_FILE_MINUS = 4'b1011,
    OP_SWAP       = 4'b1100,
    OP_ROM_HI     = 4'b1101,
    OP_ROM_LO     = 4'b1110,
    OP_ZERO_CHK   = 4'b1111
  } op_e;

  typedef struct packed {
    logic       en;
    logic [8:0] addr;
    logic [7:0] data;
  } file_wr_s;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [12:0] data;
  } stack_s;

endpackage

// ===== rtl/instr_exec.sv
// executor for moves, returns, rotates, subtracts, swap, test, xor, sleep, table reads, call
// assumes file space answers FILE_RDATA combinationally for FILE_ADDR, program memory one cycle after ROM_RD
//
// Implementation choices: the register addresses and strobed register access.
`include "exec_consts.svh"

module instr_exec (
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic [15:0]       INSTR,
  input  wire logic              INSTR_VALID,
  output      logic              INSTR_READY,
  output      logic [12:0]       PC_OUT,
  output      logic [8:0]        FILE_ADDR,
  input  wire logic [7:0]        FILE_RDATA,
  output      exec_pkg::file_wr_s FILE_WR,
  input  wire logic [12:0]       STACK_TOP,
  output      exec_pkg::stack_s  STACK_OP,
  output      logic [15:0]       ROM_ADDR,
  output      logic              ROM_RD,
  input  wire logic [15:0]       ROM_DATA,
  output      logic              OSC_STOP,
  input  wire logic              WAKE,
  output      logic [7:0]        ACC_OUT,
  output      logic              GLOBAL_IRQ_ALLOW,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output      logic [7:0]        REG_RDATA
);
  import exec_pkg::*;

  state_e      state_reg;
  op_e         op;
  logic [12:0] pc_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  table_result_reg;
  logic [7:0]  rom_pointer_hi_reg;
  logic [7:0]  rom_pointer_lo_reg;
  logic        carry_reg;
  logic        nibble_half_out_bit_reg;
  logic        zero_reg;
  logic        power_down_flag_reg;
  logic        watchdog_expiry_flag_reg;
  logic        global_irq_allow_reg;
  logic        rom_upper_reg;
  logic        rom_wait_reg;
  logic        fire;
  logic        dest_file;
  logic [7:0]  lit;
  logic [7:0]  res;
  logic [7:0]  sub_a;
  logic [8:0]  diff;
  logic [4:0]  diff_lo;
  logic        wr_acc;
  logic        wr_file;
  logic        upd_z;
  logic        upd_c;
  logic        upd_dc;
  logic        c_val;
  logic [12:0] call_target;
  logic [15:0] rom_pointer;

  assign INSTR_READY      = (state_reg == ST_EXEC);
  assign fire             = INSTR_VALID && INSTR_READY;
  assign dest_file        = INSTR[7];
  assign lit              = INSTR[7:0];
  assign FILE_ADDR        = {INSTR[15:14], INSTR[6:0]};
  assign call_target      = {INSTR[15:14], INSTR[10:0]};
  assign rom_pointer      = {rom_pointer_hi_reg, rom_pointer_lo_reg};
  assign PC_OUT           = pc_reg;
  assign ACC_OUT          = acc_reg;
  assign GLOBAL_IRQ_ALLOW = global_irq_allow_reg;

  // words outside this decoder's set fall back to idle rather than corrupting state
  always_comb
  begin
    op = OP_IDLE;
    if (INSTR[13:11] == `CALL_FIELD)
    begin
      op = OP_IDLE;
    end
    else if (INSTR[13:12] == `GRP_FILE)
    begin
      case (INSTR[11:8])
        `SUB_MOVE:  op = INSTR[7] ? OP_ZERO_CHK : OP_FILE_ACC;
        `SUB_STORE:
        begin
          if (INSTR[7])
            op = OP_ACC_FILE;
          else if (INSTR == `WORD_RET)
            op = OP_POP_PC;
          else if (INSTR == `WORD_INTERRUPT_EXIT_OP)
            op = OP_IRQ_EXIT;
          else if (INSTR == `WORD_ROM_HI)
            op = OP_ROM_HI;
          else if (INSTR == `WORD_ROM_LO)
            op = OP_ROM_LO;
          else
            op = OP_IDLE;
        end
        `SUB_ROT_L: op = OP_ROT_L;
        `SUB_ROT_R: op = OP_ROT_R;
        `SUB_MINUS: op = OP_FILE_MINUS;
        `SUB_SWAP:  op = OP_SWAP;
        `SUB_XOR:   op = OP_IDLE;
        default:    op = OP_IDLE;
      endcase
      if (INSTR[11:8] == `SUB_XOR)
        op = OP_IDLE;
    end
    else if (INSTR[13:12] == `GRP_LIT && INSTR[15:14] == 2'b00)
    begin
      case (INSTR[15:8])
        `LIT_MOVE:  op = OP_LIT_ACC;
        `LIT_POP:   op = OP_LIT_POP;
        `LIT_MINUS: op = OP_LIT_MINUS;
        default:    op = (INSTR == `WORD_SLEEP) ? OP_SLEEP : OP_IDLE;
      endcase
    end
  end

  // xor ops share a code point with nothing else, so they are decoded here beside the main table
  logic is_file_xor;
  logic is_lit_xor;
  assign is_file_xor = (INSTR[13:11] != `CALL_FIELD) && (INSTR[13:12] == `GRP_FILE) && (INSTR[11:8] == `SUB_XOR);
  assign is_lit_xor  = (INSTR[15:8] == `LIT_XOR);

  // subtraction: carry and digit carry mean "no borrow"
  always_comb
  begin
    sub_a   = (op == OP_LIT_MINUS) ? lit : FILE_RDATA;
    diff    = {1'b0, sub_a} - {1'b0, acc_reg};
    diff_lo = {1'b0, sub_a[3:0]} - {1'b0, acc_reg[3:0]};
  end

  always_comb
  begin
    res     = FILE_RDATA;
    wr_acc  = 1'b0;
    wr_file = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    c_val   = carry_reg;
    if (is_file_xor)
    begin
      res       = acc_reg ^ FILE_RDATA;
      wr_acc    = !dest_file;
      wr_file   = dest_file;
      upd_z     = 1'b1;
    end
    else if (is_lit_xor)
    begin
      res    = acc_reg ^ lit;
      wr_acc = 1'b1;
      upd_z  = 1'b1;
    end
    else
    begin
      case (op)
        OP_FILE_ACC:
        begin
          res    = FILE_RDATA;
          wr_acc = 1'b1;
          upd_z  = 1'b1;
        end
        OP_LIT_ACC, OP_LIT_POP:
        begin
          res    = lit;
          wr_acc = 1'b1;
        end
        OP_ACC_FILE:
        begin
          res     = acc_reg;
          wr_file = 1'b1;
        end
        OP_ROT_L:
        begin
          res     = {FILE_RDATA[6:0], carry_reg};
          c_val   = FILE_RDATA[7];
          upd_c   = 1'b1;
          wr_acc  = !dest_file;
          wr_file = dest_file;
        end
        OP_ROT_R:
        begin
          res     = {carry_reg, FILE_RDATA[7:1]};
          c_val   = FILE_RDATA[0];
          upd_c   = 1'b1;
          wr_acc  = !dest_file;
          wr_file = dest_file;
        end
        OP_LIT_MINUS, OP_FILE_MINUS:
        begin
          res     = diff[7:0];
          c_val   = !diff[8];
          upd_c   = 1'b1;
          upd_dc  = 1'b1;
          upd_z   = 1'b1;
          wr_acc  = (op == OP_LIT_MINUS) || !dest_file;
          wr_file = (op == OP_FILE_MINUS) && dest_file;
        end
        OP_SWAP:
        begin
          res     = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
          wr_acc  = !dest_file;
          wr_file = dest_file;
        end
        OP_ZERO_CHK:
        begin
          res   = FILE_RDATA;
          upd_z = 1'b1;
        end
        default:
        begin
          res = FILE_RDATA;
        end
      endcase
    end
  end

  // sequencing, program counter and stack traffic
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state_reg     <= ST_EXEC;
      pc_reg        <= `PC_RST;
      STACK_OP      <= '0;
      ROM_RD        <= 1'b0;
      ROM_ADDR      <= '0;
      rom_upper_reg <= 1'b0;
      OSC_STOP      <= 1'b0;
    end
    else
    begin
      STACK_OP <= '0;
      ROM_RD   <= 1'b0;
      case (state_reg)
        ST_EXEC:
        begin
          if (fire)
          begin
            pc_reg <= pc_reg + `PC_STEP;
            if (INSTR[13:11] == `CALL_FIELD)
            begin
              STACK_OP.push <= 1'b1;
              STACK_OP.data <= pc_reg + `PC_STEP;
              pc_reg        <= call_target;
              state_reg     <= ST_SECOND;
            end
            else if (op == OP_POP_PC || op == OP_IRQ_EXIT || op == OP_LIT_POP)
            begin
              STACK_OP.pop <= 1'b1;
              pc_reg       <= STACK_TOP;
              state_reg    <= ST_SECOND;
            end
            else if (op == OP_ROM_HI || op == OP_ROM_LO)
            begin
              ROM_RD        <= 1'b1;
              ROM_ADDR      <= rom_pointer;
              rom_upper_reg <= (op == OP_ROM_HI);
              state_reg     <= ST_SECOND;
            end
            else if (op == OP_SLEEP)
            begin
              OSC_STOP  <= 1'b1;
              state_reg <= ST_SLEEP;
            end
          end
        end
        ST_SECOND:
        begin
          // a table read stays one more cycle so its byte lands before the next take
          if (!ROM_RD)
            state_reg <= ST_EXEC;
        end
        ST_SLEEP:
        begin
          if (WAKE)
          begin
            OSC_STOP  <= 1'b0;
            state_reg <= ST_EXEC;
          end
        end
        default:
        begin
          state_reg <= ST_EXEC;
        end
      endcase
    end
  end

  // file writes go out registered, one cycle after the instruction is taken
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      FILE_WR <= '0;
    else
    begin
      FILE_WR.en   <= fire && wr_file;
      FILE_WR.addr <= FILE_ADDR;
      FILE_WR.data <= res;
    end
  end

  // accumulator and table result; instruction updates win over a software write
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      acc_reg          <= `BYTE_RST;
      table_result_reg <= `BYTE_RST;
    end
    else if (state_reg == ST_SECOND && ROM_RD == 1'b0 && rom_wait_reg)
    begin
      acc_reg          <= rom_upper_reg ? ROM_DATA[15:8] : ROM_DATA[7:0];
      table_result_reg <= rom_upper_reg ? ROM_DATA[15:8] : ROM_DATA[7:0];
    end
    else if (fire && wr_acc)
      acc_reg <= res;
    else if (REG_WR && REG_ADDR == `REG_ACC)
      acc_reg <= REG_WDATA;
  end

  // a table read is in flight when its read strobe was high in the previous cycle

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      rom_wait_reg <= 1'b0;
    else
      rom_wait_reg <= ROM_RD;
  end

  // status flags
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      carry_reg                <= 1'b0;
      nibble_half_out_bit_reg  <= 1'b0;
      zero_reg                 <= 1'b0;
      power_down_flag_reg      <= 1'b0;
      watchdog_expiry_flag_reg <= 1'b0;
      global_irq_allow_reg     <= 1'b0;
    end
    else
    begin
      if (REG_WR && REG_ADDR == `REG_STATUS)
      begin
        carry_reg                <= REG_WDATA[`ST_C];
        nibble_half_out_bit_reg  <= REG_WDATA[`ST_DC];
        zero_reg                 <= REG_WDATA[`ST_Z];
        power_down_flag_reg      <= REG_WDATA[`ST_PD];
        watchdog_expiry_flag_reg <= REG_WDATA[`ST_TO];
        global_irq_allow_reg     <= REG_WDATA[`ST_GIE];
      end
      if (fire)
      begin
        if (upd_c)
          carry_reg <= c_val;
        if (upd_dc)
          nibble_half_out_bit_reg <= !diff_lo[4];
        if (upd_z)
          zero_reg <= (res == `BYTE_RST);
        if (op == OP_IRQ_EXIT)
          global_irq_allow_reg <= 1'b1;
        if (op == OP_SLEEP)
        begin
          power_down_flag_reg      <= 1'b1;
          watchdog_expiry_flag_reg <= 1'b0;
        end
      end
    end
  end

  // software register port: pointer halves steer table reads, status shows core state
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      rom_pointer_hi_reg <= `BYTE_RST;
      rom_pointer_lo_reg <= `BYTE_RST;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == `REG_PTR_LO)
        rom_pointer_lo_reg <= REG_WDATA;
      else if (REG_ADDR == `REG_PTR_HI)
        rom_pointer_hi_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      REG_RDATA <= `BYTE_RST;
    else if (REG_RD)
    begin
      if (REG_ADDR == `REG_STATUS)
        REG_RDATA <= {2'b00, global_irq_allow_reg, watchdog_expiry_flag_reg, power_down_flag_reg,
                      zero_reg, nibble_half_out_bit_reg, carry_reg};
      else if (REG_ADDR == `REG_ACC)
        REG_RDATA <= acc_reg;
      else if (REG_ADDR == `REG_TABLE)
        REG_RDATA <= table_result_reg;
      else if (REG_ADDR == `REG_PTR_LO)
        REG_RDATA <= rom_pointer_lo_reg;
      else if (REG_ADDR == `REG_PTR_HI)
        REG_RDATA <= rom_pointer_hi_reg;
      else
        REG_RDATA <= `BYTE_RST;
    end
    else
      REG_RDATA <= `BYTE_RST;
  end

endmodule // instr_exec

// ===== verif/instr_exec_props.sv
// checker for the instruction executor, watching its top-level ports
// assumes one clock domain and a bind onto every instr_exec instance
module instr_exec_props (
  input wire logic               CLOCK,
  input wire logic               RST_N,
  input wire logic [15:0]        INSTR,
  input wire logic               INSTR_VALID,
  input wire logic               INSTR_READY,
  input wire logic [12:0]        PC_OUT,
  input wire logic [7:0]         FILE_RDATA,
  input wire exec_pkg::file_wr_s FILE_WR,
  input wire logic [12:0]        STACK_TOP,
  input wire exec_pkg::stack_s   STACK_OP,
  input wire logic               ROM_RD,
  input wire logic [15:0]        ROM_DATA,
  input wire logic               OSC_STOP,
  input wire logic [7:0]         ACC_OUT,
  input wire logic               GLOBAL_IRQ_ALLOW
);
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  logic        tk;
  logic [15:0] ins_q;
  logic [15:0] rom_q;
  logic [12:0] top_q;
  logic [12:0] pc_q;
  logic [7:0]  acc_q;
  logic [7:0]  frd_q;
  assign tk = INSTR_VALID && INSTR_READY;
  // one-cycle-old copies keep the properties free of sliced past values
  always_ff @(posedge CLOCK)
  begin
    ins_q <= INSTR;
    rom_q <= ROM_DATA;
    top_q <= STACK_TOP;
    pc_q  <= PC_OUT;
    acc_q <= ACC_OUT;
    frd_q <= FILE_RDATA;
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  sequence s_refuse_one;
    !INSTR_READY ##1 INSTR_READY;
  endsequence
  sequence s_rom_fetch;
    ROM_RD && !INSTR_READY ##1 !ROM_RD && !INSTR_READY ##1 INSTR_READY;
  endsequence
  AST_FILE_TO_ACC: assert property (tk && INSTR[13:7] == 7'h10 |=> ACC_OUT == frd_q)
    else $error("file move into acc wrong");
  AST_LIT_TO_ACC: assert property (tk && INSTR[15:8] == 8'h19 |=> ACC_OUT == ins_q[7:0] && INSTR_READY)
    else $error("literal move wrong");
  AST_ACC_TO_FILE: assert property (tk && INSTR[13:7] == 7'h01 |=> FILE_WR.en && FILE_WR.data == acc_q
    && FILE_WR.addr == {ins_q[15:14], ins_q[6:0]})
    else $error("store to file wrong");
  AST_IDLE: assert property (tk && INSTR == 16'h0000 |=> $stable(ACC_OUT) && !FILE_WR.en && !STACK_OP.push
    && !STACK_OP.pop && !ROM_RD && INSTR_READY)
    else $error("idle word had an effect");
  AST_RETURN: assert property (tk && INSTR == 16'h0040 |=> (STACK_OP.pop && PC_OUT == top_q) ##0 s_refuse_one)
    else $error("return wrong");
  AST_IRQ_RETURN: assert property (tk && INSTR == 16'h0060 |=> GLOBAL_IRQ_ALLOW && STACK_OP.pop
    && PC_OUT == top_q)
    else $error("interrupt return wrong");
  AST_LIT_RETURN: assert property (tk && INSTR[15:8] == 8'h18 |=>
    (ACC_OUT == ins_q[7:0] && PC_OUT == top_q && STACK_OP.pop) ##0 s_refuse_one)
    else $error("literal return wrong");
  AST_SLEEP: assert property (tk && INSTR == 16'h1E03 |=> OSC_STOP && !INSTR_READY)
    else $error("sleep entry wrong");
  AST_XOR_LIT: assert property (tk && INSTR[15:8] == 8'h1D |=> ACC_OUT == (acc_q ^ ins_q[7:0]))
    else $error("literal xor wrong");
  AST_ROM_HI: assert property (tk && INSTR == 16'h0058 |=> s_rom_fetch ##0 ACC_OUT == rom_q[15:8])
    else $error("upper table read wrong");
  AST_ROM_LO: assert property (tk && INSTR == 16'h0050 |=> s_rom_fetch ##0 ACC_OUT == rom_q[7:0])
    else $error("lower table read wrong");
  AST_CALL: assert property (tk && INSTR[13:11] == 3'b100 |=> STACK_OP.push && STACK_OP.data == pc_q + 13'h1
    && PC_OUT == {ins_q[15:14], ins_q[10:0]})
    else $error("call wrong");
endmodule // instr_exec_props

bind instr_exec instr_exec_props u_props (.CLOCK(CLOCK), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
  .INSTR_READY(INSTR_READY), .PC_OUT(PC_OUT), .FILE_RDATA(FILE_RDATA), .FILE_WR(FILE_WR), .STACK_TOP(STACK_TOP),
  .STACK_OP(STACK_OP), .ROM_RD(ROM_RD), .ROM_DATA(ROM_DATA), .OSC_STOP(OSC_STOP), .ACC_OUT(ACC_OUT),
  .GLOBAL_IRQ_ALLOW(GLOBAL_IRQ_ALLOW));

// ===== verif/exec_partner.sv
// far-side model: file register space, call stack and program memory
// assumes the executor's clock; file reads answer combinationally
module exec_partner (
  input  wire logic               CLOCK,
  input  wire logic [8:0]         FILE_ADDR,
  output      logic [7:0]         FILE_RDATA,
  input  wire exec_pkg::file_wr_s FILE_WR,
  input  wire exec_pkg::stack_s   STACK_OP,
  output      logic [12:0]        STACK_TOP,
  input  wire logic [15:0]        ROM_ADDR,
  input  wire logic               ROM_RD,
  output      logic [15:0]        ROM_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  logic [7:0]  mem [512];
  logic [12:0] stk [8];
  logic [2:0]  sp = 3'h0;
  logic        hold = 1'b0;
  logic        ph = 1'b0;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (stk[i]) stk[i] = 13'h0000;
  end
  assign FILE_RDATA = mem[FILE_ADDR];
  assign STACK_TOP = stk[sp - 3'h1];
  // word is the inverted address while fetched; a toggling pattern otherwise so stale data never matches
  assign ROM_DATA = (ROM_RD || hold) ? ~ROM_ADDR : {8{ph, ~ph}};
  always @(posedge CLOCK)
  begin
    ph <= ~ph;
    hold <= ROM_RD;
    if (FILE_WR.en)
      mem[FILE_WR.addr] <= FILE_WR.data;
    if (STACK_OP.push)
    begin
      stk[sp] <= STACK_OP.data;
      sp <= sp + 3'h1;
    end
    else if (STACK_OP.pop)
      sp <= sp - 3'h1;
  end
  task automatic poke(input logic [8:0] a, input logic [7:0] v);
    mem[a] = v;
  endtask
endmodule // exec_partner

// ===== verif/instr_exec_tb_top.sv
// self-checking bench for the instruction executor
// assumes the partner model and the bound checker are compiled alongside
`include "exec_consts.svh"
module instr_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        valid = 1'b0;
  logic        wake = 1'b0;
  logic [7:0]  ra = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ready, rom_rd, osc, irq, rrd_s, rdy_s;
  logic [12:0] pc, top;
  logic [8:0]  faddr;
  logic [7:0]  frd, acc, rdata, v;
  logic [15:0] raddr, rdat, raddr_s;
  file_wr_s    fwr, fwr_s;
  stack_s      sop, sop_s;
  int          num_errors = 0;
  int          cmp_count = 0;

  instr_exec DUT (.CLOCK(clock), .RST_N(rst_n), .INSTR(instr), .INSTR_VALID(valid), .INSTR_READY(ready),
    .PC_OUT(pc), .FILE_ADDR(faddr), .FILE_RDATA(frd), .FILE_WR(fwr), .STACK_TOP(top), .STACK_OP(sop),
    .ROM_ADDR(raddr), .ROM_RD(rom_rd), .ROM_DATA(rdat), .OSC_STOP(osc), .WAKE(wake), .ACC_OUT(acc),
    .GLOBAL_IRQ_ALLOW(irq), .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  exec_partner u_part (.CLOCK(clock), .FILE_ADDR(faddr), .FILE_RDATA(frd), .FILE_WR(fwr), .STACK_OP(sop),
    .STACK_TOP(top), .ROM_ADDR(raddr), .ROM_RD(rom_rd), .ROM_DATA(rdat));

  always #50 clock = ~clock;

  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] fw(input logic [3:0] s, input logic d, input logic [8:0] a);
    return {a[8:7], 2'b00, s, d, a[6:0]};
  endfunction
  // pulses stand only one cycle, so they are captured right after the take
  task automatic ex(input logic [15:0] w);
    @(posedge clock);
    instr <= w;
    valid <= 1'b1;
    @(posedge clock);
    valid <= 1'b0;
    #1;
    fwr_s = fwr;
    sop_s = sop;
    rrd_s = rom_rd;
    raddr_s = raddr;
    rdy_s = ready;
    for (int n = 0; n < 8 && ready !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    if (ready !== 1'b1)
    begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    ra <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic st(input logic [7:0] e);
    logic [7:0] s;
    rreg(`REG_STATUS, s);
    chk("status", e, s);
  endtask

  task automatic t_reset;
    @(posedge clock);
    #1 chk("ready", 1, ready);
    chk("acc", 0, acc);
    chk("pc", 0, pc);
    chk("osc", 0, osc);
    st(8'h00);
    rreg(8'h20, v);
    chk("unmapped", 0, v);
  endtask
  task automatic t_literal;
    wreg(`REG_STATUS, 8'h01);
    ex(16'h195A);
    chk("movl", 16'h5A, acc);
    st(8'h01);
    ex(16'h19B5);
    ex(16'h1DAF);
    chk("xorl", 16'h1A, acc);
    st(8'h01);
    ex(16'h1D1A);
    st(8'h05);
    ex(16'h1925);
    ex(16'h1F15);
    chk("subl", 16'hF0, acc);
    st(8'h02);
    ex(16'h0000);
    chk("idle acc", 16'hF0, acc);
    chk("idle wr", 0, fwr_s.en);
    st(8'h02);
  endtask
  task automatic t_file;
    u_part.poke(9'h1A5, 8'hC2);
    ex(fw(4'h8, 1'b0, 9'h1A5));
    chk("movf", 16'hC2, acc);
    ex(16'h194F);
    ex(fw(4'h0, 1'b1, 9'h0A5));
    chk("store en", 1, fwr_s.en);
    chk("store addr", 16'h0A5, fwr_s.addr);
    chk("store data", 16'h4F, fwr_s.data);
    u_part.poke(9'h1A5, 8'h00);
    ex(fw(4'h8, 1'b1, 9'h1A5));
    chk("test wr", 0, fwr_s.en);
    chk("test acc", 16'h4F, acc);
    st(8'h06);
    u_part.poke(9'h033, 8'hAF);
    ex(16'h19B5);
    ex(fw(4'h6, 1'b1, 9'h033));
    chk("xorf data", 16'h1A, fwr_s.data);
    chk("xorf acc", 16'hB5, acc);
    u_part.poke(9'h1A5, 8'hA5);
    ex(fw(4'hE, 1'b0, 9'h1A5));
    chk("swap", 16'h5A, acc);
    st(8'h02);
  endtask
  task automatic t_rot;
    wreg(`REG_STATUS, 8'h00);
    u_part.poke(9'h010, 8'hE6);
    ex(fw(4'hD, 1'b0, 9'h010));
    chk("rotl", 16'hCC, acc);
    st(8'h01);
    ex(fw(4'hC, 1'b1, 9'h010));
    chk("rotr", 16'hF3, fwr_s.data);
    chk("rotr acc", 16'hCC, acc);
    st(8'h00);
  endtask
  task automatic t_sub;
    logic [7:0] f [3] = '{8'h03, 8'h02, 8'h01};
    logic [7:0] r [3] = '{8'h01, 8'h00, 8'hFF};
    logic [7:0] s [3] = '{8'h03, 8'h07, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      ex(16'h1902);
      u_part.poke(9'h077, f[i]);
      ex(fw(4'h2, 1'b1, 9'h077));
      chk("subf", r[i], fwr_s.data);
      st(s[i]);
    end
  endtask
  task automatic t_rom;
    wreg(`REG_PTR_LO, 8'h34);
    wreg(`REG_PTR_HI, 8'h02);
    ex(16'h0050);
    chk("rom rd", 1, rrd_s);
    chk("rom addr", 16'h0234, raddr_s);
    chk("lo acc", 16'hCB, acc);
    rreg(`REG_TABLE, v);
    chk("lo tab", 16'hCB, v);
    ex(16'h0058);
    chk("hi acc", 16'hFD, acc);
    rreg(`REG_TABLE, v);
    chk("hi tab", 16'hFD, v);
  endtask
  task automatic t_sleep;
    int n;
    @(posedge clock);
    instr <= 16'h1E03;
    valid <= 1'b1;
    @(posedge clock);
    valid <= 1'b0;
    #1 chk("osc", 1, osc);
    repeat (3) @(posedge clock);
    #1 chk("asleep", 0, ready);
    @(posedge clock);
    wake <= 1'b1;
    for (n = 0; n < 8 && ready !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    wake <= 1'b0;
    #1 chk("woken", 1, ready);
    if (ready !== 1'b1)
      final_report();
    chk("osc off", 0, osc);
    rreg(`REG_STATUS, v);
    chk("power flags", 16'h08, v & 8'h18);
  endtask
  // each call lands far from PC zero so a pop of a stale entry would show
  task automatic t_ret;
    logic [12:0] p;
    logic [15:0] w [3] = '{16'h0040, 16'h1877, 16'h0060};
    for (int i = 0; i < 3; i++)
    begin
      p = pc;
      ex(16'hA234);
      chk("push", 1, sop_s.push);
      chk("ret addr", p + 13'h1, sop_s.data);
      chk("target", 16'h1234, pc);
      ex(w[i]);
      chk("pop", 1, sop_s.pop);
      chk("refuse", 0, rdy_s);
      chk("pc back", p + 13'h1, pc);
    end
    chk("retl acc", 16'h77, acc);
    chk("irq allow", 1, irq);
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_literal();
    t_file();
    t_rot();
    t_sub();
    t_rom();
    t_sleep();
    t_ret();
    final_report();
  end
endmodule // instr_exec_tb_top
